// ==== core/psa_pkg.sv ====
/*
  Constants for the PHY status and auto-negotiation register subset: register
  indexes, field positions, reset values and fixed ability bits.
  Assumes a 5-bit register index, as seen by the indirect management path.
*/
package psa_pkg;

  // Register indexes as seen through the indirect management access path.
  localparam logic [4:0] PSA_IDX_STATUS = 5'h01;
  localparam logic [4:0] PSA_IDX_IDENT_HIGH = 5'h02;
  localparam logic [4:0] PSA_IDX_IDENT_LOW = 5'h03;
  localparam logic [4:0] PSA_IDX_ADVERTISE = 5'h04;
  localparam logic [4:0] PSA_IDX_PARTNER = 5'h05;

  // Basic status field positions.
  localparam int PSA_ST_T4 = 15;
  localparam int PSA_ST_ABIL_HI = 14;
  localparam int PSA_ST_ABIL_LO = 11;
  localparam int PSA_ST_AN_DONE = 5;
  localparam int PSA_ST_RFAULT = 4;
  localparam int PSA_ST_AN_ABLE = 3;
  localparam int PSA_ST_LINK = 2;
  localparam int PSA_ST_JABBER = 1;
  localparam int PSA_ST_EXT_CAP = 0;

  // Fixed ability values of the basic status register.
  localparam logic PSA_T4_ABLE = 1'b0;
  localparam logic [3:0] PSA_TECH_ABLE = 4'hf;
  localparam logic PSA_AN_ABLE = 1'b1;
  localparam logic PSA_EXT_CAP = 1'b1;

  // Advertisement and partner ability field positions.
  localparam int PSA_AB_NEXT_PAGE = 15;
  localparam int PSA_AB_ACK = 14;
  localparam int PSA_AB_RFAULT = 13;
  localparam int PSA_AB_PAUSE_SYM = 10;
  localparam int PSA_AB_PAUSE_ASYM = 11;
  localparam int PSA_AB_T4 = 9;

  // Writable bits of the advertisement register and its reset value.
  localparam logic [15:0] PSA_ADV_WMASK = 16'h2dff;
  localparam logic [15:0] PSA_ADV_RESET = 16'h01e1;

  // Captured bits of the partner ability register and its reset value.
  localparam logic [15:0] PSA_LPA_CMASK = 16'hafff;
  localparam logic [15:0] PSA_LPA_RESET = 16'h0001;

  // Identifier field split of the second identifier register.
  localparam int PSA_ID_MODEL_LO = 4;
  localparam int PSA_ID_OUI_LO = 10;

endpackage : psa_pkg

// ==== core/psa_phy_status_regs.sv ====
/*
  Status, identifier, advertisement and partner ability registers of a
  10/100 PHY, reached by index over the indirect management access path,
  and the pause resolution that follows a completed negotiation.
  Assumes the management requests, the negotiation engine outputs and the
  line status indications all come from logic on i_core_clk.
*/
// Overview of operation
// - Status bit 15 reads 0: no 100BASE-T4 ability.
// - Status bits 14 to 11 read 1: TX full, TX half, 10 full, 10 half.
// - Status bit 5 follows negotiation complete; resets to 0.
// - Status bit 4 latches high on remote fault.
// - Status bit 3 reads 1: negotiation able.
// - Status bit 2 is link state, latching low, reset 0.
// - Status bit 1 latches high on jabber.
// - Status bit 0 reads 1: extended registers present.
// - First identifier register holds identifier bits 3 to 18.
// - Second identifier bits 15 to 10 hold identifier bits 19 to 24.
// - Second identifier holds model in 9:4 and revision in 3:0.
// - Advertised pause field 11:10 is writable, reset 00.
// - With both pause kinds advertised, at most one is chosen after completion.
// - Advertised abilities 8:5 reset to 1; selector resets to 00001.
// - Partner next page bit is read-only, reset 0; no next page exchange.
// - Partner acknowledge bit sets once a code word arrives.
// - Partner pause field 11:10 is read-only, reset 00.
// - Partner fault, T4, abilities and selector read-only; selector resets 00001.
`timescale 1ns/1ns
module psa_phy_status_regs #(
  parameter logic [15:0] ID_OUI_HIGH = 16'h1234, // Arbitrary value.
  parameter logic [5:0] ID_OUI_LOW = 6'h15, // Arbitrary value.
  parameter logic [5:0] ID_MODEL = 6'h2a, // Arbitrary value.
  parameter logic [3:0] ID_REVISION = 4'h3 // Arbitrary value.
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [4:0] i_reg_idx,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_an_complete,
  input wire logic i_remote_fault,
  input wire logic i_link_up,
  input wire logic i_jabber,
  input wire logic i_partner_valid,
  input wire logic [15:0] i_partner_word,
  output logic [15:0] o_advertise,
  output logic o_pause_sym,
  output logic o_pause_asym_tx,
  output logic o_pause_asym_rx
);

  logic an_done;
  logic rfault_lat;
  logic link_lat;
  logic jabber_lat;
  logic [15:0] ident_high;
  logic [15:0] ident_low;
  logic [15:0] partner;
  logic rd_status;
  logic [15:0] status_word;
  logic [15:0] next_rdata;
  logic loc_sym;
  logic loc_asym;
  logic lp_sym;
  logic lp_asym;

  // A status read is the event that releases the latched bits.
  assign rd_status = i_reg_rd && (i_reg_idx == psa_pkg::PSA_IDX_STATUS);

  // Negotiation complete is a live level, registered once.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      an_done <= 1'b0;
    end else begin
      an_done <= i_an_complete;
    end
  end

  // Latching-high bits: a read reloads the live condition, so an event in
  // the read cycle itself is kept and never lost.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rfault_lat <= 1'b0;
      jabber_lat <= 1'b0;
    end else if (rd_status) begin
      rfault_lat <= i_remote_fault;
      jabber_lat <= i_jabber;
    end else begin
      rfault_lat <= rfault_lat | i_remote_fault;
      jabber_lat <= jabber_lat | i_jabber;
    end
  end

  // Latching-low link bit: any drop holds it low until software reads it.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      link_lat <= 1'b0;
    end else if (rd_status) begin
      link_lat <= i_link_up;
    end else begin
      link_lat <= link_lat & i_link_up;
    end
  end

  // Identifier registers are writable; reset restores the identity values.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ident_high <= ID_OUI_HIGH;
      ident_low <= {ID_OUI_LOW, ID_MODEL, ID_REVISION};
    end else if (i_reg_wr) begin
      if (i_reg_idx == psa_pkg::PSA_IDX_IDENT_HIGH) begin
        ident_high <= i_reg_wdata;
      end
      if (i_reg_idx == psa_pkg::PSA_IDX_IDENT_LOW) begin
        ident_low <= i_reg_wdata;
      end
    end
  end

  // Advertisement register; reserved bits are masked so they read zero.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_advertise <= psa_pkg::PSA_ADV_RESET;
    end else if (i_reg_wr && (i_reg_idx == psa_pkg::PSA_IDX_ADVERTISE)) begin
      o_advertise <= i_reg_wdata & psa_pkg::PSA_ADV_WMASK;
    end
  end

  // Partner ability is loaded only by the negotiation engine; writes from
  // the management side never reach it.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      partner <= psa_pkg::PSA_LPA_RESET;
    end else if (i_partner_valid) begin
      partner <= (i_partner_word & psa_pkg::PSA_LPA_CMASK)
        | (16'h0001 << psa_pkg::PSA_AB_ACK);
    end
  end

  // Basic status word, fixed abilities merged with live and latched bits.
  always_comb begin
    status_word = 16'h0000;
    status_word[psa_pkg::PSA_ST_T4] = psa_pkg::PSA_T4_ABLE;
    status_word[psa_pkg::PSA_ST_ABIL_HI:psa_pkg::PSA_ST_ABIL_LO] =
      psa_pkg::PSA_TECH_ABLE;
    status_word[psa_pkg::PSA_ST_AN_DONE] = an_done;
    status_word[psa_pkg::PSA_ST_RFAULT] = rfault_lat;
    status_word[psa_pkg::PSA_ST_AN_ABLE] = psa_pkg::PSA_AN_ABLE;
    status_word[psa_pkg::PSA_ST_LINK] = link_lat;
    status_word[psa_pkg::PSA_ST_JABBER] = jabber_lat;
    status_word[psa_pkg::PSA_ST_EXT_CAP] = psa_pkg::PSA_EXT_CAP;
  end

  // Read multiplexer; indexes outside this subset answer zero.
  always_comb begin
    case (i_reg_idx)
      psa_pkg::PSA_IDX_STATUS: next_rdata = status_word;
      psa_pkg::PSA_IDX_IDENT_HIGH: next_rdata = ident_high;
      psa_pkg::PSA_IDX_IDENT_LOW: next_rdata = ident_low;
      psa_pkg::PSA_IDX_ADVERTISE: next_rdata = o_advertise;
      psa_pkg::PSA_IDX_PARTNER: next_rdata = partner;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data is registered and held until the next read, one cycle late.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  assign loc_sym = o_advertise[psa_pkg::PSA_AB_PAUSE_SYM];
  assign loc_asym = o_advertise[psa_pkg::PSA_AB_PAUSE_ASYM];
  assign lp_sym = partner[psa_pkg::PSA_AB_PAUSE_SYM];
  assign lp_asym = partner[psa_pkg::PSA_AB_PAUSE_ASYM];

  // Pause resolution after completion picks one setting at most; until the
  // negotiation completes no pause is enabled, so stale partner data is moot.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_pause_sym <= 1'b0;
      o_pause_asym_tx <= 1'b0;
      o_pause_asym_rx <= 1'b0;
    end else begin
      o_pause_sym <= an_done && loc_sym && lp_sym;
      o_pause_asym_tx <= an_done && !loc_sym && loc_asym && lp_sym && lp_asym;
      o_pause_asym_rx <= an_done && loc_sym && loc_asym && !lp_sym && lp_asym;
    end
  end

  // Checks on the register behaviour.
  property p_fixed_t4;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    rd_status |=> o_reg_rvalid && !o_reg_rdata[15];
  endproperty
  a_fixed_t4: assert property (p_fixed_t4) else $error("T4 bit not zero");

  property p_fixed_tech;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    rd_status |=> o_reg_rdata[14:11] == 4'hf && o_reg_rdata[10:6] == 5'h00;
  endproperty
  a_fixed_tech: assert property (p_fixed_tech) else $error("Ability bits wrong");

  property p_an_done;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    rd_status ##1 $past(i_rst_n, 2) |-> o_reg_rdata[5] == $past(i_an_complete, 2);
  endproperty
  a_an_done: assert property (p_an_done) else $error("Complete bit mismatch");

  property p_rfault_latch;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_remote_fault ##1 rd_status |=> o_reg_rdata[4];
  endproperty
  a_rfault_latch: assert property (p_rfault_latch) else $error("Fault not latched");

  property p_fixed_ext;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    rd_status |=> o_reg_rdata[3] && o_reg_rdata[0];
  endproperty
  a_fixed_ext: assert property (p_fixed_ext) else $error("Able bits not set");

  property p_link_low;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !i_link_up ##1 rd_status |=> !o_reg_rdata[2];
  endproperty
  a_link_low: assert property (p_link_low) else $error("Link drop not latched");

  property p_jabber_latch;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_jabber ##1 (rd_status && !i_jabber) ##1 rd_status |=> !o_reg_rdata[1];
  endproperty
  a_jabber_latch: assert property (p_jabber_latch) else $error("Jabber not released");

  property p_pause_one;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $onehot0({o_pause_sym, o_pause_asym_tx, o_pause_asym_rx})
      && ($past(an_done) || !(o_pause_sym || o_pause_asym_tx || o_pause_asym_rx));
  endproperty
  a_pause_one: assert property (p_pause_one) else $error("Pause not exclusive");

  property p_adv_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_wr && i_reg_idx == psa_pkg::PSA_IDX_ADVERTISE
      |=> o_advertise == ($past(i_reg_wdata) & psa_pkg::PSA_ADV_WMASK);
  endproperty
  a_adv_write: assert property (p_adv_write) else $error("Advert write lost");

  property p_partner_ack;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_partner_valid ##1 (i_reg_rd && i_reg_idx == psa_pkg::PSA_IDX_PARTNER && !i_partner_valid)
      |=> o_reg_rdata[14] && o_reg_rdata[12] == 1'b0;
  endproperty
  a_partner_ack: assert property (p_partner_ack) else $error("Ack bit not set");

  property p_unmapped;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_rd && (i_reg_idx == 5'h00 || i_reg_idx > 5'h05) |=> o_reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");

  // Port timing: the answer flag follows each read by exactly one cycle.
  property p_rvalid_pulse;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    o_reg_rvalid == $past(i_reg_rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("Read answer late");

  // Read data must hold between reads so a slow master still sees it.
  property p_rdata_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !$past(i_reg_rd) |-> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved");

  // Management writes never reach the partner register.
  property p_partner_ro;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_wr && i_reg_idx == psa_pkg::PSA_IDX_PARTNER && !i_partner_valid
      |=> partner == $past(partner);
  endproperty
  a_partner_ro: assert property (p_partner_ro) else $error("Partner was written");

  property p_ident_high_wr;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_wr && i_reg_idx == psa_pkg::PSA_IDX_IDENT_HIGH |=> ident_high == $past(i_reg_wdata);
  endproperty
  a_ident_high_wr: assert property (p_ident_high_wr) else $error("Ident high lost");

  property p_ident_low_wr;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_wr && i_reg_idx == psa_pkg::PSA_IDX_IDENT_LOW |=> ident_low == $past(i_reg_wdata);
  endproperty
  a_ident_low_wr: assert property (p_ident_low_wr) else $error("Ident low lost");

  // Latch set paths: an event always lands, even in a read cycle.
  property p_jabber_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_jabber |=> jabber_lat;
  endproperty
  a_jabber_set: assert property (p_jabber_set) else $error("Jabber event lost");

  property p_rfault_set;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_remote_fault |=> rfault_lat;
  endproperty
  a_rfault_set: assert property (p_rfault_set) else $error("Fault event lost");

  property p_link_drop;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !i_link_up |=> !link_lat;
  endproperty
  a_link_drop: assert property (p_link_drop) else $error("Link drop lost");

  property p_an_follow;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    an_done == $past(i_an_complete);
  endproperty
  a_an_follow: assert property (p_an_follow) else $error("Complete not tracked");

  // The acknowledge bit is forced on whatever the code word carries.
  property p_partner_load;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_partner_valid |=> partner == (($past(i_partner_word) & 16'hafff) | 16'h4000);
  endproperty
  a_partner_load: assert property (p_partner_load) else $error("Partner load wrong");

  property p_adv_reserved;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (o_advertise & ~psa_pkg::PSA_ADV_WMASK) == 16'h0000;
  endproperty
  a_adv_reserved: assert property (p_adv_reserved) else $error("Reserved bit set");

  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) rd_status ##1 o_reg_rdata[4]);
  cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_reg_wr && i_reg_idx == psa_pkg::PSA_IDX_ADVERTISE);
  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) i_partner_valid);
  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_pause_asym_rx);
  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) o_pause_sym);

endmodule : psa_phy_status_regs

// ==== sim/psa_mgmt_model.sv ====
/*
  Behavioural model of the MAC management port that reaches the PHY registers
  by index, with read and write tasks called by the testbench.
  Assumes one clock shared with the register block and a one-cycle read answer.
*/
`timescale 1ns/1ns
module psa_mgmt_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [4:0] o_reg_idx,
  output logic [15:0] o_reg_wdata
);
  // Idle port at time zero; no request until the bench asks for one.
  initial begin
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_idx = 5'h00;
    o_reg_wdata = 16'h0000;
  end

  // Indexed read; idle lines show the inverse so stale values cannot pass.
  task automatic rd(input logic [4:0] idx, output logic [15:0] data);
    int n = 0;
    o_reg_idx = idx;
    o_reg_rd = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_idx = ~idx;
    while (i_reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hxxxx;
    // Let an edge pass so a following request never retoggles a line in this step.
    @(posedge i_core_clk);
    #1;
  endtask : rd

  // Indexed write of one whole 16-bit word.
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    o_reg_idx = idx;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_idx = ~idx;
    o_reg_wdata = ~d;
    @(posedge i_core_clk);
    #1;
  endtask : wr
endmodule : psa_mgmt_model

// ==== sim/psa_phy_status_regs_tb.sv ====
/*
  Self-checking bench for the PHY status and negotiation register subset.
  Assumes the management model drives the register port and the bench drives line status.
*/
`timescale 1ns/1ns
module psa_phy_status_regs_tb;
  localparam logic [15:0] OUI_HI = 16'h2468; // Arbitrary value.
  localparam logic [15:0] ID_LO = {6'h0b, 6'h11, 4'h5}; // Arbitrary values.
  localparam logic [15:0] ST = 16'h7809;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_rd, reg_wr, reg_rvalid, pause_sym, pause_tx, pause_rx;
  logic [4:0] reg_idx;
  logic [15:0] reg_wdata, reg_rdata, advertise;
  logic an_complete = 1'b0;
  logic remote_fault = 1'b0;
  logic link_up = 1'b0;
  logic jabber = 1'b0;
  logic partner_valid = 1'b0;
  logic [15:0] partner_word = 16'h0000;
  int failures = 0;
  int n_checks = 0;

  psa_phy_status_regs #(.ID_OUI_HIGH(OUI_HI), .ID_OUI_LOW(ID_LO[15:10]),
    .ID_MODEL(ID_LO[9:4]), .ID_REVISION(ID_LO[3:0])) psa_phy_status_regs_i (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_reg_rd(reg_rd), .i_reg_wr(reg_wr),
    .i_reg_idx(reg_idx), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .o_reg_rvalid(reg_rvalid), .i_an_complete(an_complete), .i_remote_fault(remote_fault),
    .i_link_up(link_up), .i_jabber(jabber), .i_partner_valid(partner_valid),
    .i_partner_word(partner_word), .o_advertise(advertise), .o_pause_sym(pause_sym),
    .o_pause_asym_tx(pause_tx), .o_pause_asym_rx(pause_rx));

  psa_mgmt_model psa_mgmt_model_i (.i_core_clk(core_clk), .i_reg_rdata(reg_rdata),
    .i_reg_rvalid(reg_rvalid), .o_reg_rd(reg_rd), .o_reg_wr(reg_wr), .o_reg_idx(reg_idx),
    .o_reg_wdata(reg_wdata));

  // An 8 ns period gives the 125 MHz core clock.
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic rdchk(input logic [4:0] idx, input logic [15:0] exp, input string what);
    logic [15:0] d;
    psa_mgmt_model_i.rd(idx, d);
    chk16(d, exp, what);
  endtask : rdchk

  task automatic pulse_partner(input logic [15:0] w);
    partner_valid = 1'b1;
    partner_word = w;
    step();
    partner_valid = 1'b0;
    partner_word = ~w;
  endtask : pulse_partner

  task automatic t_reset_values();
    rdchk(5'h01, ST, "status reset");
    rdchk(5'h02, OUI_HI, "ident high");
    rdchk(5'h03, ID_LO, "ident low");
    rdchk(5'h04, 16'h01e1, "advertise reset");
    rdchk(5'h05, 16'h0001, "partner reset");
    chk16(advertise, 16'h01e1, "advertise out");
  endtask : t_reset_values

  // Read-only places must ignore writes, and reserved bits must stay clear.
  task automatic t_advertise();
    psa_mgmt_model_i.wr(5'h04, 16'hffff);
    rdchk(5'h04, 16'h2dff, "advertise mask");
    chk16(advertise, 16'h2dff, "advertise out");
    psa_mgmt_model_i.wr(5'h01, 16'h0000);
    rdchk(5'h01, ST, "status write");
    rdchk(5'h1f, 16'h0000, "unmapped");
  endtask : t_advertise

  // A single-cycle event must survive until read, then the live state returns.
  task automatic t_latches();
    link_up = 1'b1;
    remote_fault = 1'b1;
    jabber = 1'b1;
    step();
    remote_fault = 1'b0;
    jabber = 1'b0;
    step();
    rdchk(5'h01, ST | 16'h0012, "latched");
    rdchk(5'h01, ST | 16'h0004, "live");
    link_up = 1'b0;
    step();
    link_up = 1'b1;
    step();
    rdchk(5'h01, ST, "link drop");
    rdchk(5'h01, ST | 16'h0004, "link back");
  endtask : t_latches

  task automatic t_partner();
    pulse_partner(16'hb7ff);
    rdchk(5'h05, 16'he7ff, "partner word");
    psa_mgmt_model_i.wr(5'h05, 16'h0000);
    rdchk(5'h05, 16'he7ff, "partner write");
  endtask : t_partner

  // Local side offers both pause kinds; each partner code picks at most one.
  task automatic t_pause();
    logic [2:0] exp_tab [4] = '{3'b000, 3'b100, 3'b001, 3'b100};
    psa_mgmt_model_i.wr(5'h04, 16'h0de1);
    pulse_partner(16'h0de1);
    step();
    chk16({13'h0, pause_sym, pause_tx, pause_rx}, 16'h0000, "pause early");
    rdchk(5'h01, ST | 16'h0004, "not complete");
    an_complete = 1'b1;
    repeat (3) step();
    rdchk(5'h01, ST | 16'h0024, "complete");
    for (int p = 0; p < 4; p++) begin
      pulse_partner(16'h01e1 | (16'(p) << 10));
      repeat (3) step();
      chk16({13'h0, pause_sym, pause_tx, pause_rx}, {13'h0, exp_tab[p]}, "pause");
    end
  endtask : t_pause

  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Reset is held for five edges before the first request.
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_reset_values();
    t_advertise();
    t_latches();
    t_partner();
    t_pause();
    wrap_up();
  end

  // The whole run needs under a hundred cycles, so this limit only trips on a hang.
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule : psa_phy_status_regs_tb
